// *** atc_regs.svh ***
`ifndef ATC_REGS_SVH
`define ATC_REGS_SVH
// task file register addresses (3-bit, as on the ata address lines)
`define ATC_A_DATA      3'h0
`define ATC_A_ERROR     3'h1
`define ATC_A_SECCNT    3'h2
`define ATC_A_SECNUM    3'h3
`define ATC_A_CYLLO     3'h4
`define ATC_A_CYLHI     3'h5
`define ATC_A_DRVHEAD   3'h6
`define ATC_A_STATUS    3'h7
`define ATC_A_ALTSTAT   3'h6
`define ATC_A_DRVADDR   3'h7
// device control bits
`define ATC_DC_SOFT_RESET_REQUEST     2
`define ATC_DC_MASK     1
`define ATC_DC_ONE      3
// drive/head bits
`define ATC_DH_DRV      4
`define ATC_DH_HEAD_HI  3
// status bits
`define ATC_ST_BUSY     7
`define ATC_ST_RDY      6
`define ATC_ST_DSC      4
`define ATC_ST_ERR      0
// error register abort code
`define ATC_ERR_ABORT   8'h04
`define ATC_DIAG_PASS   8'h01
`define ATC_DRVHEAD_RST 8'hA0
`define ATC_DC_INIT     8'h08
// status words: ready with seek complete, busy, ready with error
`define ATC_STAT_READY  8'h50
`define ATC_STAT_BUSY   8'h80
`define ATC_STAT_ABORT  8'h51
// controller's own register port offsets
`define ATC_R_CMD       4'h0
`define ATC_R_ADDR      4'h1
`define ATC_R_WDATA     4'h2
`define ATC_R_RDATA     4'h3
`define ATC_R_STAT      4'h4
`define ATC_R_INTR      4'h5
`define ATC_ST_IDLE     2'h0
`endif

// *** atc_pkg.sv ***
package atc_pkg;
  typedef enum logic [3:0] {
    ATC_OP_NONE     = 4'b0000,
    ATC_OP_PWRCHK   = 4'b0001,
    ATC_OP_DIAG     = 4'b0010,
    ATC_OP_ERASE    = 4'b0011,
    ATC_OP_WRNOERS  = 4'b0100,
    ATC_OP_WRMNOERS = 4'b0101,
    ATC_OP_MEDIA    = 4'b0110,
    ATC_OP_NODATA   = 4'b0111,
    ATC_OP_BAD      = 4'b1000
  } atc_op_e;
  typedef struct packed {
    atc_op_e op;
    logic    retry;
  } atc_dec_s;
endpackage

// *** atc_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// task file bus: host drives address and strobes, data is split in/out with an enable on read bit 7 only
interface atc_link_if;
  logic       cs_n;
  logic       ctl_sel;
  logic [2:0] addr;
  logic       wr;
  logic       rd;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       rdata_oe7;
  logic       mem_mode;
  logic       irq_o;
  logic       irq_oe;
  modport dev  (input cs_n, ctl_sel, addr, wr, rd, wdata, mem_mode,
                output rdata, rdata_oe7, irq_o, irq_oe);
  modport host (output cs_n, ctl_sel, addr, wr, rd, wdata, mem_mode,
                input rdata, rdata_oe7, irq_o, irq_oe);
endinterface
`default_nettype wire

// *** atc_opdec.sv ***
`timescale 1ns/1ps
`default_nettype none
module atc_opdec
  import atc_pkg::*;
(
  input  wire logic [7:0]       OPCODE,
  output atc_pkg::atc_dec_s     DEC
);
  import atc_pkg::*;
  function automatic atc_dec_s decode(input logic [7:0] c);
    atc_dec_s d;
    d.op    = ATC_OP_BAD;
    d.retry = 1'b1;
    // paired codes: first is with retry, second without
    case (c)
      8'hE5: d.op = ATC_OP_PWRCHK;
      8'h98: begin d.op = ATC_OP_PWRCHK; d.retry = 1'b0; end
      8'h90: d.op = ATC_OP_DIAG;
      8'hC0: d.op = ATC_OP_ERASE;
      8'hCD: d.op = ATC_OP_WRMNOERS;
      8'h38: d.op = ATC_OP_WRNOERS;
      8'h20, 8'h22, 8'h30, 8'h32, 8'h40: d.op = ATC_OP_MEDIA;
      8'h21, 8'h23, 8'h31, 8'h33, 8'h41: begin
        d.op    = ATC_OP_MEDIA;
        d.retry = 1'b0;
      end
      8'h50, 8'hC4, 8'hC5, 8'h87, 8'h3C: d.op = ATC_OP_MEDIA;
      8'hE3, 8'hE1, 8'hE6, 8'hE2, 8'hE0: d.op = ATC_OP_NODATA;
      8'h97, 8'h95, 8'h99, 8'h96, 8'h94: begin
        d.op    = ATC_OP_NODATA;
        d.retry = 1'b0;
      end
      8'hEC, 8'h91, 8'hE4, 8'h03, 8'hEF, 8'hC6, 8'hF5, 8'hE8: d.op = ATC_OP_NODATA;
      default: begin
        if (c[7:4] == 4'h1 || c[7:4] == 4'h7) begin
          d.op = ATC_OP_NODATA;
        end
      end
    endcase
    return d;
  endfunction
  assign DEC = decode(OPCODE);
endmodule
`default_nettype wire

// *** atc_dev.sv ***
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "atc_regs.svh"
module atc_dev
  import atc_pkg::*;
#(
  parameter int EXEC_CYCLES = 8,
  parameter int SOFT_RESET_REQUEST_CYCLES = 4
) (
  input  wire logic         SYS_CLK,
  input  wire logic         RESETN,
  atc_link_if.dev           LINK,
  input  wire logic         DRIVE_ID,
  input  wire logic         MEDIA_DONE,
  output logic              MEDIA_START,
  output atc_pkg::atc_op_e  MEDIA_OP,
  output logic              MEDIA_RETRY,
  output logic [27:0]       MEDIA_LBA,
  output logic [7:0]        MEDIA_COUNT
);
  import atc_pkg::*;

  typedef enum logic [1:0] {
    ATC_D_READY = 2'b00,
    ATC_D_EXEC  = 2'b01,
    ATC_D_SOFT_RESET_REQUEST  = 2'b10
  } atc_dstate_e;

  atc_dstate_e state_q;
  logic [7:0]  status_q, error_q, seccnt_q, secnum_q, cyllo_q, cylhi_q, drvhead_q;
  logic        mask_q, soft_reset_request_bit_q, pend_q;
  logic [7:0]  cnt_q;
  logic [7:0]  rdata_q;
  logic        oe7_q;
  atc_dec_s    dec;
  atc_op_e     op_q;
  logic        wr_tf, wr_ctl, rd_tf, rd_ctl, selected, cmd_wr, done_evt;

  atc_opdec u_dec (
    .OPCODE (LINK.wdata),
    .DEC    (dec)
  );

  assign wr_tf    = !LINK.cs_n && LINK.wr && !LINK.ctl_sel;
  assign wr_ctl   = !LINK.cs_n && LINK.wr && LINK.ctl_sel;
  assign rd_tf    = !LINK.cs_n && LINK.rd && !LINK.ctl_sel;
  assign rd_ctl   = !LINK.cs_n && LINK.rd && LINK.ctl_sel;
  assign selected = drvhead_q[`ATC_DH_DRV] == DRIVE_ID;
  // diagnostic addressed to drive 0 still runs here
  assign cmd_wr   = wr_tf && LINK.addr == `ATC_A_STATUS && state_q == ATC_D_READY
                    && (selected || dec.op == ATC_OP_DIAG);
  assign done_evt = state_q == ATC_D_EXEC && (cnt_q == 8'h00 || MEDIA_DONE);

  // device control: only bits 2:1 kept, 7:4 ignored
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      mask_q     <= 1'b0;
      soft_reset_request_bit_q <= 1'b0;
    end else if (wr_ctl && LINK.addr == `ATC_A_ALTSTAT) begin
      mask_q     <= LINK.wdata[`ATC_DC_MASK];
      soft_reset_request_bit_q <= LINK.wdata[`ATC_DC_SOFT_RESET_REQUEST];
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      seccnt_q  <= 8'h01;
      secnum_q  <= 8'h01;
      cyllo_q   <= 8'h00;
      cylhi_q   <= 8'h00;
      drvhead_q <= `ATC_DRVHEAD_RST;
    end else if (state_q == ATC_D_SOFT_RESET_REQUEST) begin
      seccnt_q  <= 8'h01;
      secnum_q  <= 8'h01;
      cyllo_q   <= 8'h00;
      cylhi_q   <= 8'h00;
      drvhead_q <= `ATC_DRVHEAD_RST;
    end else if (wr_tf) begin
      case (LINK.addr)
        `ATC_A_SECCNT:  seccnt_q  <= LINK.wdata;
        `ATC_A_SECNUM:  secnum_q  <= LINK.wdata;
        `ATC_A_CYLLO:   cyllo_q   <= LINK.wdata;
        `ATC_A_CYLHI:   cylhi_q   <= LINK.wdata;
        `ATC_A_DRVHEAD: drvhead_q <= LINK.wdata;
        default: ;
      endcase
    end
  end

  // command sequencing
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      state_q  <= ATC_D_READY;
      cnt_q    <= 8'h00;
      op_q     <= ATC_OP_NONE;
      status_q <= `ATC_STAT_READY;
      error_q  <= `ATC_DIAG_PASS;
    end else begin
      case (state_q)
        ATC_D_READY: begin
          if (wr_ctl && LINK.addr == `ATC_A_ALTSTAT && LINK.wdata[`ATC_DC_SOFT_RESET_REQUEST]) begin
            state_q  <= ATC_D_SOFT_RESET_REQUEST;
            cnt_q    <= 8'(SOFT_RESET_REQUEST_CYCLES);
            status_q <= `ATC_STAT_BUSY;
          end else if (cmd_wr) begin
            op_q <= dec.op;
            if (dec.op == ATC_OP_BAD) begin
              status_q <= `ATC_STAT_ABORT;
              error_q  <= `ATC_ERR_ABORT;
            end else begin
              state_q  <= ATC_D_EXEC;
              cnt_q    <= 8'(EXEC_CYCLES);
              status_q <= `ATC_STAT_BUSY;
              error_q  <= 8'h00;
            end
          end
        end
        ATC_D_EXEC: begin
          if (wr_ctl && LINK.addr == `ATC_A_ALTSTAT && LINK.wdata[`ATC_DC_SOFT_RESET_REQUEST]) begin
            state_q  <= ATC_D_SOFT_RESET_REQUEST;
            cnt_q    <= 8'(SOFT_RESET_REQUEST_CYCLES);
          end else if (done_evt) begin
            state_q  <= ATC_D_READY;
            status_q <= `ATC_STAT_READY;
            // power query leaves the sector count as the host wrote it
            if (op_q == ATC_OP_DIAG) begin
              error_q <= `ATC_DIAG_PASS;
            end
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        ATC_D_SOFT_RESET_REQUEST: begin
          // held while bit2 stays set, then back to ready
          if (soft_reset_request_bit_q) begin
            cnt_q <= 8'(SOFT_RESET_REQUEST_CYCLES);
          end else if (cnt_q == 8'h00) begin
            state_q  <= ATC_D_READY;
            status_q <= `ATC_STAT_READY;
            error_q  <= `ATC_DIAG_PASS;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        default: state_q <= ATC_D_READY;
      endcase
    end
  end

  // interrupt pending; completion wins over a clearing status read
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      pend_q <= 1'b0;
    end else if (state_q == ATC_D_SOFT_RESET_REQUEST) begin
      pend_q <= 1'b0;
    end else if (done_evt || (cmd_wr && dec.op == ATC_OP_BAD)) begin
      pend_q <= 1'b1;
    end else if (rd_tf && LINK.addr == `ATC_A_STATUS) begin
      pend_q <= 1'b0;
    end
  end

  // read data one cycle after strobe
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      rdata_q <= 8'h00;
      oe7_q   <= 1'b0;
    end else begin
      oe7_q <= 1'b1;
      if (rd_ctl && LINK.addr == `ATC_A_DRVADDR) begin
        oe7_q   <= 1'b0;
        rdata_q <= {1'b0, 1'b1, ~drvhead_q[`ATC_DH_HEAD_HI:0],
                    ~(selected && DRIVE_ID), ~(selected && !DRIVE_ID)};
      end else if (rd_ctl || (rd_tf && LINK.addr == `ATC_A_STATUS)) begin
        rdata_q <= status_q;
      end else if (rd_tf) begin
        case (LINK.addr)
          `ATC_A_ERROR:   rdata_q <= error_q;
          `ATC_A_SECCNT:  rdata_q <= seccnt_q;
          `ATC_A_SECNUM:  rdata_q <= secnum_q;
          `ATC_A_CYLLO:   rdata_q <= cyllo_q;
          `ATC_A_CYLHI:   rdata_q <= cylhi_q;
          `ATC_A_DRVHEAD: rdata_q <= drvhead_q;
          default:        rdata_q <= 8'h00;
        endcase
      end
    end
  end

  assign LINK.rdata     = rdata_q;
  assign LINK.rdata_oe7 = oe7_q;
  assign LINK.irq_o     = 1'b0;
  // memory mode drives the line regardless of the mask
  assign LINK.irq_oe    = pend_q && selected && (LINK.mem_mode || !mask_q);

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      MEDIA_START <= 1'b0;
      MEDIA_OP    <= ATC_OP_NONE;
      MEDIA_RETRY <= 1'b1;
      MEDIA_LBA   <= 28'h000_0000;
      MEDIA_COUNT <= 8'h00;
    end else begin
      MEDIA_START <= cmd_wr && dec.op != ATC_OP_BAD;
      if (cmd_wr) begin
        MEDIA_OP    <= dec.op;
        MEDIA_RETRY <= dec.retry;
        MEDIA_LBA   <= {drvhead_q[`ATC_DH_HEAD_HI:0], cylhi_q, cyllo_q, secnum_q};
        MEDIA_COUNT <= seccnt_q;
      end
    end
  end
endmodule
`default_nettype wire

// *** atc_host.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "atc_regs.svh"
module atc_host
  import atc_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        RESETN,
  atc_link_if.host         LINK,
  input  wire logic        MEM_MODE,
  input  wire logic [3:0]  ADDR,
  input  wire logic [7:0]  WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic [7:0]       RDATA,
  output logic             IRQ_SEEN
);
  import atc_pkg::*;
  logic [3:0] taddr_q;
  logic [7:0] tdata_q, rd_q, data_q;
  logic       go_wr_q, go_rd_q, cap_q, busy_q;

  // R_ADDR: bit3 selects control block, bits 2:0 register
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      taddr_q <= 4'h0;
      tdata_q <= 8'h00;
      go_wr_q <= 1'b0;
      go_rd_q <= 1'b0;
    end else begin
      go_wr_q <= 1'b0;
      go_rd_q <= 1'b0;
      if (WR) begin
        case (ADDR)
          `ATC_R_ADDR:  taddr_q <= WDATA[3:0];
          `ATC_R_WDATA: tdata_q <= WDATA;
          `ATC_R_CMD: begin
            go_wr_q <= WDATA[0];
            go_rd_q <= WDATA[1];
          end
          default: ;
        endcase
      end
    end
  end

  // device control: bit0 zero, bit3 one forced on every control write
  always_comb begin
    LINK.cs_n    = !(go_wr_q || go_rd_q);
    LINK.ctl_sel = taddr_q[3];
    LINK.addr    = taddr_q[2:0];
    LINK.wr      = go_wr_q;
    LINK.rd      = go_rd_q;
    LINK.wdata   = taddr_q[3] ? ((tdata_q | `ATC_DC_INIT) & 8'h0E) : tdata_q;
    LINK.mem_mode = MEM_MODE;
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      cap_q  <= 1'b0;
      data_q <= 8'h00;
      busy_q <= 1'b0;
    end else begin
      cap_q  <= go_rd_q;
      busy_q <= go_wr_q || go_rd_q || cap_q;
      if (cap_q) begin
        data_q <= {LINK.rdata_oe7 & LINK.rdata[7], LINK.rdata[6:0]};
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      rd_q     <= 8'h00;
      IRQ_SEEN <= 1'b0;
    end else begin
      IRQ_SEEN <= LINK.irq_oe && !LINK.irq_o;
      if (RD) begin
        case (ADDR)
          `ATC_R_RDATA: rd_q <= data_q;
          `ATC_R_STAT:  rd_q <= {6'h00, busy_q, IRQ_SEEN};
          `ATC_R_ADDR:  rd_q <= {4'h0, taddr_q};
          default:      rd_q <= 8'h00;
        endcase
      end
    end
  end
  // are software's duty: parameters written before the command
  assign RDATA = rd_q;
endmodule
`default_nettype wire

// *** atc_link_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module atc_link_properties (
  input wire logic       SYS_CLK,
  input wire logic       RESETN,
  input wire logic       cs_n,
  input wire logic       ctl_sel,
  input wire logic [2:0] addr,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       rdata_oe7,
  input wire logic       mem_mode,
  input wire logic       irq_o,
  input wire logic       irq_oe
);
  logic [3:0] head_q;
  logic       mask_q;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  // shadow copies of the head field and the write-only mask bit the device holds
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      head_q <= 4'h0;
    end else if (!cs_n && wr && ctl_sel && addr == 3'h6 && wdata[2]) begin
      // soft reset puts the drive/head register back to head zero
      head_q <= 4'h0;
    end else if (!cs_n && wr && !ctl_sel && addr == 3'h6) begin
      head_q <= wdata[3:0];
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      mask_q <= 1'b0;
    end else if (!cs_n && wr && ctl_sel && addr == 3'h6) begin
      mask_q <= wdata[1];
    end
  end
  sequence link_rd(logic c, logic [2:0] a);
    !cs_n && rd && ctl_sel == c && addr == a;
  endsequence
  sequence soft_reset_request_wr;
    !cs_n && wr && ctl_sel && addr == 3'h6 && wdata[2];
  endsequence
  alt_keeps_irq_a: assert property (link_rd(1'b1, 3'h6) ##0 irq_oe |=> irq_oe)
    else $error("alternate status read dropped the interrupt");
  stat_clears_irq_a: assert property (link_rd(1'b0, 3'h7) ##0 irq_oe |=> !irq_oe)
    else $error("status read left the interrupt pending");
  mask_blocks_irq_a: assert property (mask_q && !mem_mode |-> !irq_oe)
    else $error("masked interrupt driven");
  irq_level_a: assert property (irq_oe |-> irq_o == 1'b0)
    else $error("interrupt line driven high");
  bit7_float_a: assert property (link_rd(1'b1, 3'h7) |=> !rdata_oe7)
    else $error("drive address bit 7 driven");
  head_inverted_a: assert property (link_rd(1'b1, 3'h7) |=> rdata[5:2] == ~head_q)
    else $error("drive address head bits wrong");
  drvsel_bits_a: assert property (link_rd(1'b1, 3'h7) |=> rdata[6] && rdata[1:0] != 2'b00)
    else $error("drive address select bits wrong");
  soft_reset_request_clears_a: assert property (soft_reset_request_wr |-> ##[1:2] !irq_oe ##1 !irq_oe)
    else $error("soft reset kept the interrupt");
endmodule
`default_nettype wire

// *** ata_taskfile_control_decode_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module ata_taskfile_control_decode_tb_top;
  import atc_pkg::*;
  logic        SYS_CLK = 1'b0;
  logic        RESETN = 1'b0;
  logic        MEM_MODE = 1'b0;
  logic        WR = 1'b0;
  logic        RD = 1'b0;
  logic        DRIVE_ID = 1'b0;
  logic [3:0]  ADDR = 4'h0;
  logic [7:0]  WDATA = 8'h00;
  logic [7:0]  RDATA;
  logic        IRQ_SEEN;
  logic        MEDIA_START;
  logic        MEDIA_RETRY;
  atc_op_e     MEDIA_OP;
  logic [27:0] MEDIA_LBA;
  logic [7:0]  MEDIA_COUNT;
  int          num_errors = 0;
  int          comparisons = 0;
  int          starts = 0;
  atc_op_e     op_seen;
  logic        rt_seen;
  logic [7:0]  v;
  logic [7:0]  codes [10] = '{8'hE5, 8'h98, 8'h90, 8'hC0, 8'hCD, 8'h38, 8'h20, 8'h21, 8'hE3,
                             8'h97};
  atc_op_e     ops [10] = '{ATC_OP_PWRCHK, ATC_OP_PWRCHK, ATC_OP_DIAG, ATC_OP_ERASE,
                            ATC_OP_WRMNOERS, ATC_OP_WRNOERS, ATC_OP_MEDIA, ATC_OP_MEDIA,
                            ATC_OP_NODATA, ATC_OP_NODATA};
  atc_link_if link ();
  atc_dev #(.EXEC_CYCLES(8), .SOFT_RESET_REQUEST_CYCLES(4)) u_atc_dev (.SYS_CLK(SYS_CLK), .RESETN(RESETN),
    .LINK(link), .DRIVE_ID(DRIVE_ID), .MEDIA_DONE(1'b0), .MEDIA_START(MEDIA_START),
    .MEDIA_OP(MEDIA_OP), .MEDIA_RETRY(MEDIA_RETRY), .MEDIA_LBA(MEDIA_LBA),
    .MEDIA_COUNT(MEDIA_COUNT));
  atc_host u_atc_host (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .LINK(link), .MEM_MODE(MEM_MODE),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ_SEEN(IRQ_SEEN));
  atc_link_properties u_props (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .cs_n(link.cs_n),
    .ctl_sel(link.ctl_sel), .addr(link.addr), .wr(link.wr), .rd(link.rd),
    .wdata(link.wdata), .rdata(link.rdata), .rdata_oe7(link.rdata_oe7),
    .mem_mode(link.mem_mode), .irq_o(link.irq_o), .irq_oe(link.irq_oe));
  always #20 SYS_CLK = ~SYS_CLK;
  always @(posedge SYS_CLK) begin
    if (MEDIA_START === 1'b1) begin
      starts <= starts + 1;
      op_seen <= MEDIA_OP;
      rt_seen <= MEDIA_RETRY;
    end
  end
  task automatic chk(input string name, input logic [27:0] exp, input logic [27:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic hw(input logic [3:0] a, input logic [7:0] d);
    @(posedge SYS_CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge SYS_CLK);
    WR <= 1'b0;
  endtask
  task automatic hr(input logic [3:0] a, output logic [7:0] d);
    @(posedge SYS_CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge SYS_CLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask
  // link address: bit 3 picks the control block
  task automatic lw(input logic [3:0] la, input logic [7:0] d);
    hw(4'h1, {4'h0, la});
    hw(4'h2, d);
    hw(4'h0, 8'h01);
    repeat (4) @(posedge SYS_CLK);
  endtask
  task automatic lr(input logic [3:0] la, output logic [7:0] d);
    hw(4'h1, {4'h0, la});
    hw(4'h0, 8'h02);
    repeat (4) @(posedge SYS_CLK);
    hr(4'h3, d);
  endtask
  // polls the alternate view so a pending interrupt survives the wait
  task automatic wait_idle();
    for (int i = 0; i < 30; i++) begin
      lr(4'hE, v);
      if (v[7] === 1'b0) break;
    end
  endtask
  task automatic cmd(input logic [7:0] op, input int n);
    int s;
    s = starts;
    lw(4'h7, op);
    wait_idle();
    chk("media starts", 28'(s + n), 28'(starts));
  endtask
  function automatic logic [6:0] da(input logic [3:0] hd, input logic drv, input logic id);
    logic sel;
    sel = (drv == id);
    return {1'b1, ~hd, ~(sel & id), ~(sel & ~id)};
  endfunction
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #(40 * 40000);
    num_errors++;
    finish_test();
  end
  initial begin
    repeat (10) @(posedge SYS_CLK);
    RESETN <= 1'b1;
    lr(4'h7, v);
    chk("status", 8'h50, v);
    lr(4'hF, v);
    chk("drive address", da(4'h0, 1'b0, 1'b0), v[6:0]);
    $display("test reset done");
    lw(4'h2, 8'h05);
    lw(4'h3, 8'h03);
    lw(4'h4, 8'h12);
    lw(4'h5, 8'h34);
    lw(4'h6, 8'hE2);
    for (int i = 0; i < 10; i++) begin
      cmd(codes[i], 1);
      chk("opcode", ops[i], op_seen);
      if (i < 2 || i > 5) chk("retry", 28'(i % 2 == 0), rt_seen);
      chk("irq after done", 1'b1, IRQ_SEEN);
      lr(4'h7, v);
      chk("status done", 8'h50, v);
      chk("irq after status", 1'b0, IRQ_SEEN);
    end
    chk("lba", 28'h234_1203, MEDIA_LBA);
    chk("count", 8'h05, MEDIA_COUNT);
    lr(4'hF, v);
    chk("drive address head", da(4'h2, 1'b0, 1'b0), v[6:0]);
    $display("test opcodes done");
    cmd(8'hFF, 0);
    lr(4'hE, v);
    chk("alt status abort", 8'h51, v);
    chk("irq after alt", 1'b1, IRQ_SEEN);
    lr(4'h1, v);
    chk("error abort", 8'h04, v);
    lr(4'h7, v);
    chk("irq cleared", 1'b0, IRQ_SEEN);
    $display("test abort done");
    lw(4'hE, 8'h0A);
    cmd(8'hE5, 1);
    chk("irq masked", 1'b0, IRQ_SEEN);
    @(posedge SYS_CLK);
    MEM_MODE <= 1'b1;
    repeat (3) @(posedge SYS_CLK);
    chk("irq memory mode", 1'b1, IRQ_SEEN);
    MEM_MODE <= 1'b0;
    lw(4'hE, 8'hF8);
    chk("irq unmasked", 1'b1, IRQ_SEEN);
    lr(4'h7, v);
    $display("test mask done");
    lw(4'h6, 8'hF0);
    cmd(8'hE5, 0);
    lr(4'hF, v);
    chk("drive address other", da(4'h0, 1'b1, 1'b0), v[6:0]);
    @(posedge SYS_CLK);
    DRIVE_ID <= 1'b1;
    lr(4'hF, v);
    chk("drive address one", da(4'h0, 1'b1, 1'b1), v[6:0]);
    lw(4'h6, 8'hE0);
    cmd(8'h90, 1);
    chk("irq deselected", 1'b0, IRQ_SEEN);
    lr(4'h1, v);
    chk("diag code", 8'h01, v);
    lr(4'h7, v);
    @(posedge SYS_CLK);
    DRIVE_ID <= 1'b0;
    $display("test select done");
    cmd(8'hE5, 1);
    chk("irq before reset", 1'b1, IRQ_SEEN);
    lw(4'hE, 8'h0C);
    lr(4'hE, v);
    chk("busy in reset", 1'b1, v[7]);
    lw(4'hE, 8'h08);
    wait_idle();
    chk("irq after reset", 1'b0, IRQ_SEEN);
    lr(4'h7, v);
    chk("status after reset", 8'h50, v);
    lw(4'h6, 8'hA0);
    $display("test soft reset done");
    finish_test();
  end
endmodule
`default_nettype wire
